// file: design/sss_map.svh
// Register addresses, field positions and timing counts for the spindle start-up block.
// Included by the serial slave and top design files and by the bench; holds definitions only.
`ifndef SSS_MAP_SVH
`define SSS_MAP_SVH

// Seven-bit serial register addresses
`define SSS_ADDR_SPIN_CTRL  7'h17
`define SSS_ADDR_STATUS     7'h3f
`define SSS_ADDR_PROBE      7'h47
`define SSS_ADDR_SYSCTRL    7'h4f
`define SSS_ADDR_CHIP_ID    7'h7f

// Spindle control fields
`define SSS_SC_STEP         0
`define SSS_SC_AUTO         1
`define SSS_SC_CRST         2
`define SSS_SC_RUN          3
`define SSS_SC_DRV          4
// Inductive probe fields
`define SSS_PR_ARM          3
`define SSS_PR_LO           4
`define SSS_PR_HI           5
// System control field
`define SSS_SY_DBL          4

// Serial frame layout, LSB first
`define SSS_FRAME_LAST      5'h0f
`define SSS_READ_START      5'h08
`define SSS_WC_POS          0
`define SSS_ADDR_LSB        1
`define SSS_ADDR_MSB        7
`define SSS_DATA_LSB        8
`define SSS_DATA_MSB        15

// Start-up timing in system clock periods
`define SSS_ALIGN_CYC       2560000
`define SSS_INCR_CYC        7680000
`define SSS_RESYNC_CYC      8400000
`define SSS_ZC_MIN_CYC      1000

// Sequencer phases 1 to 6
`define SSS_PHASE_FIRST     3'h1
`define SSS_PHASE_LAST      3'h6
`define SSS_READ_IDLE       8'h00

`endif

// file: design/sss_pkg.sv
// Types shared by the spindle start-up sequencer files.
// Assumes sss_map.svh supplies all numeric constants.
package sss_pkg;

  // Start-up sequencer states
  typedef enum logic [2:0] {
    SSS_IDLE,
    SSS_RESYNC,
    SSS_ALIGN,
    SSS_INCR,
    SSS_GO
  } sss_state_e;

  // Status byte, bit 7 first
  typedef struct packed {
    logic go_n;
    logic align_n;
    logic speed_in_window;
    logic bemf_blanking_view;
    logic fault;
    logic stall_detect_n;
    logic overtemp_warning_n;
    logic overtemp_shutdown_n;
  } sss_status_s;

  // One decoded serial write
  typedef struct packed {
    logic       stb;
    logic [6:0] addr;
    logic [7:0] data;
  } sss_write_s;

endpackage

// file: design/sss_interval_timer.sv
// One-shot down counter timing resync, align and increment intervals.
// Assumes load and count come from logic on mclk_i.
`timescale 1ns/1ps
`default_nettype none
module sss_interval_timer #(
  parameter int TW = 25
) (
  input  wire logic          mclk_i,
  input  wire logic          rst_n_i,
  input  wire logic          ce_i,
  input  wire logic          load_i,
  input  wire logic          abort_i,
  input  wire logic [TW-1:0] count_i,
  output logic               done_o
);

  logic [TW-1:0] cnt_q;
  logic          run_q;

  // Load takes count minus one so the interval spans exactly count cycles
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q  <= '0;
      run_q  <= 1'b0;
      done_o <= 1'b0;
    end else if (ce_i) begin
      done_o <= 1'b0;
      if (abort_i) begin
        run_q <= 1'b0;
      end else if (load_i) begin
        cnt_q <= count_i - TW'(1);
        run_q <= 1'b1;
      end else if (run_q) begin
        if (cnt_q == '0) begin
          run_q  <= 1'b0;
          done_o <= 1'b1;
        end else begin
          cnt_q <= cnt_q - TW'(1);
        end
      end
    end
  end

endmodule
`default_nettype wire

// file: design/sss_serial_slave.sv
// Serial register port: 16-bit frames, write-control bit, address, data.
// Assumes clock, enable and data inputs already synchronised to mclk_i.
`timescale 1ns/1ps
`default_nettype none
module sss_serial_slave
  import sss_pkg::*;
(
  input  wire logic       mclk_i,
  input  wire logic       rst_n_i,
  input  wire logic       ce_i,
  input  wire logic       frame_en_i,
  input  wire logic       sclk_rise_i,
  input  wire logic       sclk_fall_i,
  input  wire logic       sdi_i,
  input  wire logic [7:0] rd_data_i,
  output logic [6:0]      rd_addr_o,
  output sss_write_s      wr_o,
  output logic            sdo_o,
  output logic            sdo_oe_o
);
`include "sss_map.svh"

  logic [4:0]  cnt_q;
  logic [15:0] sh_q;
  logic        load_q;
  logic        rd_act_q;
  logic [7:0]  out_q;

  assign rd_addr_o = sh_q[`SSS_ADDR_MSB:`SSS_ADDR_LSB];

  // Bits land at their frame position; write fires on the sixteenth rise
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q  <= 5'h00;
      sh_q   <= 16'h0000;
      load_q <= 1'b0;
      wr_o   <= '0;
    end else if (ce_i) begin
      wr_o.stb <= 1'b0;
      load_q   <= 1'b0;
      if (!frame_en_i) begin
        cnt_q <= 5'h00;
      end else if (sclk_rise_i && cnt_q <= `SSS_FRAME_LAST) begin
        sh_q[cnt_q[3:0]] <= sdi_i;
        cnt_q            <= cnt_q + 5'h01;
        load_q           <= (cnt_q == `SSS_READ_START - 5'h01);
        if (cnt_q == `SSS_FRAME_LAST && !sh_q[`SSS_WC_POS]) begin
          wr_o.stb  <= 1'b1;
          wr_o.addr <= sh_q[`SSS_ADDR_MSB:`SSS_ADDR_LSB];
          wr_o.data <= {sdi_i, sh_q[`SSS_DATA_MSB-1:`SSS_DATA_LSB]};
        end
      end
    end
  end

  // Read byte captured once the address is complete; driven from the falling edge after bit 8
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_act_q <= 1'b0;
      out_q    <= 8'h00;
      sdo_o    <= 1'b0;
      sdo_oe_o <= 1'b0;
    end else if (ce_i) begin
      if (!frame_en_i) begin
        rd_act_q <= 1'b0;
        sdo_oe_o <= 1'b0;
      end else if (load_q && sh_q[`SSS_WC_POS]) begin
        rd_act_q <= 1'b1;
        out_q    <= rd_data_i;
      end else if (rd_act_q && sclk_fall_i) begin
        sdo_oe_o <= 1'b1;
        sdo_o    <= out_q[0];
        out_q    <= {1'b0, out_q[7:1]};
      end
    end
  end

endmodule
`default_nettype wire

// file: design/sss_top.sv
// Spindle start-up sequencer with status flags and serial register port.
// Assumes analog comparators and the serial host sit outside the mclk_i domain.
//
// Summary of operation
// - Shutdown flag drops on 160C trip, spindle tristates, voice-coil retract starts.
// - While shut down, only serial reads work; flag recovers after 60C cooling.
// - Warning flag low above about 125C, recovers alone, triggers no action.
// - Stall flag low without back-EMF; spindle and voice-coil outputs tristate.
// - Fault flag high on rapid deceleration or fast zero-cross toggling; report only.
// - Blanking bit mirrors the back-EMF mask live, low while masked.
// - Speed bit high while speed error is within plus or minus 16us.
// - Bit 6 low during internal align, bit 7 low during internal go.
// - Status and identity registers read only, others write only; identity gives revision.
// - Auto launch with run and drive: wait resync, then align at phase 1.
// - Sequencer returns to phase 1 at power-on and on commutation reset.
// - After align time advance two to phase 3, after increment two more, go.
// - Align time 2.56M clocks, increment time 7.68M clocks.
// - Doubling bit doubles align and increment times.
// - Without auto launch, each step write from 0 to 1 advances one phase.
// - Zero-cross toggle output flips at every back-EMF zero crossing.
// - Probe arm presets coil sensing and turns toggle output into threshold flag.
// - Probe limit code selects .15V, .20V, .25V or .30V threshold.
// - Frame: write bit, seven-bit address, eight data bits, LSB first, 16 rises.
`timescale 1ns/1ps
`default_nettype none
`include "sss_map.svh"
module sss_top
  import sss_pkg::*;
#(
  parameter int         ALIGN_CYC  = `SSS_ALIGN_CYC,
  parameter int         INCR_CYC   = `SSS_INCR_CYC,
  parameter int         RESYNC_CYC = `SSS_RESYNC_CYC,
  parameter int         ZC_MIN_CYC = `SSS_ZC_MIN_CYC,
  parameter logic [7:0] DEVICE_REV = 8'h5a // Arbitrary revision value
) (
  input  wire logic       mclk_i,
  input  wire logic       rst_n_i,
  input  wire logic       ce_i,
  input  wire logic       power_good_n_i,
  input  wire logic       serial_frame_enable_i,
  input  wire logic       serial_clk_i,
  input  wire logic       serial_io_line_i,
  output logic            serial_io_line_o,
  output logic            serial_io_line_oe_o,
  input  wire logic       temp_trip_i,
  input  wire logic       temp_recovered_i,
  input  wire logic       temp_warn_i,
  input  wire logic       bemf_missing_i,
  input  wire logic       bemf_mask_n_i,
  input  wire logic       speed_ok_i,
  input  wire logic       decel_fast_i,
  input  wire logic       bemf_zc_i,
  input  wire logic       probe_hit_i,
  output logic [2:0]      phase_o,
  output logic            spindle_drive_en_o,
  output logic            vcm_drive_en_o,
  output logic            retract_start_o,
  output logic            zero_cross_toggle_o,
  output logic            probe_arm_o,
  output logic [1:0]      probe_limit_o,
  output logic            standby_o
);

  localparam int NSYNC = 13;
  localparam int TW    = 25;
  localparam int ZW    = 16;

  // Input bit order in the synchroniser bank
  localparam int I_PGOOD = 0;
  localparam int I_FRAME = 1;
  localparam int I_SCLK  = 2;
  localparam int I_SDI   = 3;
  localparam int I_TRIP  = 4;
  localparam int I_RECOV = 5;
  localparam int I_WARN  = 6;
  localparam int I_STALL = 7;
  localparam int I_MASKN = 8;
  localparam int I_SPEED = 9;
  localparam int I_DECEL = 10;
  localparam int I_ZC    = 11;
  localparam int I_PROBE = 12;

  // Wraps the phase around 1..6 after advancing one or two positions
  function automatic logic [2:0] sss_phase_add(input logic [2:0] ph, input logic [2:0] n);
    logic [3:0] sum;
    sum = {1'b0, ph} + {1'b0, n};
    if (sum > {1'b0, `SSS_PHASE_LAST}) begin
      sum = sum - {1'b0, `SSS_PHASE_LAST};
    end
    return sum[2:0];
  endfunction

  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] s1_q;
  logic [NSYNC-1:0] s2_q;
  logic [NSYNC-1:0] s3_q;
  logic [NSYNC-1:0] filt_q;
  logic [NSYNC-1:0] filt_prev_q;

  assign pin_raw = {probe_hit_i, bemf_zc_i, decel_fast_i, speed_ok_i, bemf_mask_n_i,
                    bemf_missing_i, temp_warn_i, temp_recovered_i, temp_trip_i,
                    serial_io_line_i, serial_clk_i, serial_frame_enable_i, power_good_n_i};

  // Three-stage synchroniser; a level counts once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          s1_q[gi]        <= 1'b0;
          s2_q[gi]        <= 1'b0;
          s3_q[gi]        <= 1'b0;
          filt_q[gi]      <= 1'b0;
          filt_prev_q[gi] <= 1'b0;
        end else if (ce_i) begin
          s1_q[gi]        <= pin_raw[gi];
          s2_q[gi]        <= s1_q[gi];
          s3_q[gi]        <= s2_q[gi];
          filt_prev_q[gi] <= filt_q[gi];
          if (s2_q[gi] == s3_q[gi]) begin
            filt_q[gi] <= s3_q[gi];
          end
        end
      end
    end
  endgenerate

  logic pgood;
  logic sclk_rise;
  logic sclk_fall;
  logic zc_evt;
  assign pgood     = filt_q[I_PGOOD];
  assign sclk_rise = filt_q[I_SCLK] & ~filt_prev_q[I_SCLK];
  assign sclk_fall = ~filt_q[I_SCLK] & filt_prev_q[I_SCLK];
  // Comparator flips at each crossing, so both edges are crossings
  assign zc_evt    = filt_q[I_ZC] ^ filt_prev_q[I_ZC];

  // Serial port
  sss_write_s  wr;
  logic [6:0]  rd_addr;
  logic [7:0]  rd_data;
  sss_status_s status;

  sss_serial_slave u_serial (
    .mclk_i      (mclk_i),
    .rst_n_i     (rst_n_i),
    .ce_i        (ce_i),
    .frame_en_i  (filt_q[I_FRAME]),
    .sclk_rise_i (sclk_rise),
    .sclk_fall_i (sclk_fall),
    .sdi_i       (filt_q[I_SDI]),
    .rd_data_i   (rd_data),
    .rd_addr_o   (rd_addr),
    .wr_o        (wr),
    .sdo_o       (serial_io_line_o),
    .sdo_oe_o    (serial_io_line_oe_o)
  );

  // Only status and identity answer reads; reading changes nothing
  always_comb begin
    unique case (rd_addr)
      `SSS_ADDR_STATUS:  rd_data = status;
      `SSS_ADDR_CHIP_ID: rd_data = DEVICE_REV;
      default:           rd_data = `SSS_READ_IDLE;
    endcase
  end

  // Thermal shutdown flag with hysteresis supplied by trip and recover levels
  logic shutdown_n_q;
  logic standby;
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      shutdown_n_q    <= 1'b1;
      retract_start_o <= 1'b0;
    end else if (ce_i) begin
      retract_start_o <= 1'b0;
      if (filt_q[I_TRIP]) begin
        shutdown_n_q    <= 1'b0;
        retract_start_o <= shutdown_n_q;
      end else if (filt_q[I_RECOV]) begin
        shutdown_n_q <= 1'b1;
      end
    end
  end
  assign standby = ~shutdown_n_q;

  // Write-only control registers; writes ignored in standby and cleared without power
  logic step_q, auto_q, crst_q, run_q, drv_q, arm_q, lim_lo_q, lim_hi_q, dbl_q;
  logic wr_ok, step_rise;
  assign wr_ok     = wr.stb & ~standby & pgood;
  assign step_rise = wr_ok & (wr.addr == `SSS_ADDR_SPIN_CTRL)
                   & wr.data[`SSS_SC_STEP] & ~step_q;
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      {step_q, auto_q, crst_q, run_q, drv_q} <= 5'h00;
      {arm_q, lim_lo_q, lim_hi_q, dbl_q}     <= 4'h0;
    end else if (ce_i) begin
      if (!pgood) begin
        {step_q, auto_q, crst_q, run_q, drv_q} <= 5'h00;
        {arm_q, lim_lo_q, lim_hi_q, dbl_q}     <= 4'h0;
      end else if (wr_ok) begin
        unique case (wr.addr)
          `SSS_ADDR_SPIN_CTRL: begin
            step_q <= wr.data[`SSS_SC_STEP];
            auto_q <= wr.data[`SSS_SC_AUTO];
            crst_q <= wr.data[`SSS_SC_CRST];
            run_q  <= wr.data[`SSS_SC_RUN];
            drv_q  <= wr.data[`SSS_SC_DRV];
          end
          `SSS_ADDR_PROBE: begin
            arm_q    <= wr.data[`SSS_PR_ARM];
            lim_lo_q <= wr.data[`SSS_PR_LO];
            lim_hi_q <= wr.data[`SSS_PR_HI];
          end
          `SSS_ADDR_SYSCTRL: dbl_q <= wr.data[`SSS_SY_DBL];
          default: ;
        endcase
      end
    end
  end

  // Start-up sequencer
  sss_state_e state_q;
  logic       launch_ok;
  logic       ext_stepped_q;
  logic       tmr_load;
  logic       tmr_done;
  logic [TW-1:0] tmr_count;
  logic [TW-1:0] align_len;
  logic [TW-1:0] incr_len;

  assign launch_ok = auto_q & run_q & drv_q & pgood & ~standby & ~filt_q[I_STALL];
  assign align_len = dbl_q ? TW'(ALIGN_CYC) << 1 : TW'(ALIGN_CYC);
  assign incr_len  = dbl_q ? TW'(INCR_CYC) << 1 : TW'(INCR_CYC);

  // Timer loads on entry to each timed state
  always_comb begin
    tmr_load  = 1'b0;
    tmr_count = TW'(RESYNC_CYC);
    unique case (state_q)
      SSS_IDLE:   tmr_load = launch_ok & ~ext_stepped_q;
      SSS_RESYNC: begin
        tmr_load  = tmr_done;
        tmr_count = align_len;
      end
      SSS_ALIGN:  begin
        tmr_load  = tmr_done;
        tmr_count = incr_len;
      end
      SSS_INCR:   tmr_load = 1'b0;
      SSS_GO:     tmr_load = 1'b0;
    endcase
  end

  sss_interval_timer #(
    .TW (TW)
  ) u_timer (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .ce_i    (ce_i),
    .load_i  (tmr_load),
    .abort_i (~launch_ok),
    .count_i (tmr_count),
    .done_o  (tmr_done)
  );

  // Auto launch after host stepping jumps straight to zero-crossing control
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= SSS_IDLE;
    end else if (ce_i) begin
      if (!launch_ok) begin
        state_q <= SSS_IDLE;
      end else begin
        unique case (state_q)
          SSS_IDLE:   state_q <= ext_stepped_q ? SSS_GO : SSS_RESYNC;
          SSS_RESYNC: if (tmr_done) state_q <= SSS_ALIGN;
          SSS_ALIGN:  if (tmr_done) state_q <= SSS_INCR;
          SSS_INCR:   if (tmr_done) state_q <= SSS_GO;
          SSS_GO:     state_q <= SSS_GO;
        endcase
      end
    end
  end

  // Remembers host stepping so a later hand-over skips the internal start-up
  // A step in the same cycle as a clear wins, so no host step is forgotten
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ext_stepped_q <= 1'b0;
    end else if (ce_i) begin
      if (step_rise && !auto_q) begin
        ext_stepped_q <= 1'b1;
      end else if (!pgood || !run_q || crst_q) begin
        ext_stepped_q <= 1'b0;
      end
    end
  end

  // Phase register; held at phase 1 without power or while reset is written
  logic [2:0] phase_q;
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phase_q <= `SSS_PHASE_FIRST;
    end else if (ce_i) begin
      if (!pgood || crst_q) begin
        phase_q <= `SSS_PHASE_FIRST;
      end else if (standby) begin
        phase_q <= phase_q;
      end else if (launch_ok && (state_q == SSS_ALIGN || state_q == SSS_INCR) && tmr_done) begin
        phase_q <= sss_phase_add(phase_q, 3'h2);
      end else if (launch_ok && state_q == SSS_GO && zc_evt) begin
        phase_q <= sss_phase_add(phase_q, 3'h1);
      end else if (!auto_q && step_rise) begin
        phase_q <= sss_phase_add(phase_q, 3'h1);
      end
    end
  end
  assign phase_o = phase_q;

  // Crossing spacing check for the fault flag; counter saturates
  logic [ZW-1:0] zc_gap_q;
  logic          fast_zc_q;
  logic          zc_tog_q;
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      zc_gap_q  <= '0;
      fast_zc_q <= 1'b0;
      zc_tog_q  <= 1'b0;
    end else if (ce_i) begin
      if (zc_evt) begin
        fast_zc_q <= (zc_gap_q < ZW'(ZC_MIN_CYC));
        zc_gap_q  <= '0;
        zc_tog_q  <= ~zc_tog_q;
      end else if (zc_gap_q != '1) begin
        zc_gap_q <= zc_gap_q + ZW'(1);
      end
    end
  end

  // Status flags follow their sources; nothing here is sticky
  always_comb begin
    status.overtemp_shutdown_n = shutdown_n_q;
    status.overtemp_warning_n  = ~filt_q[I_WARN];
    status.stall_detect_n      = ~filt_q[I_STALL];
    status.fault               = filt_q[I_DECEL] | fast_zc_q;
    status.bemf_blanking_view  = filt_q[I_MASKN];
    status.speed_in_window     = filt_q[I_SPEED];
    status.align_n             = ~(state_q == SSS_ALIGN || state_q == SSS_INCR);
    status.go_n                = ~(state_q == SSS_GO);
  end

  // Registered drive and pin outputs
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      spindle_drive_en_o  <= 1'b0;
      vcm_drive_en_o      <= 1'b0;
      zero_cross_toggle_o <= 1'b0;
      probe_arm_o         <= 1'b0;
      probe_limit_o       <= 2'h0;
      standby_o           <= 1'b0;
    end else if (ce_i) begin
      spindle_drive_en_o  <= run_q & drv_q & pgood & shutdown_n_q & ~filt_q[I_STALL];
      vcm_drive_en_o      <= pgood & ~filt_q[I_STALL];
      zero_cross_toggle_o <= arm_q ? filt_q[I_PROBE] : zc_tog_q;
      probe_arm_o         <= arm_q & ~standby;
      probe_limit_o       <= {lim_hi_q, lim_lo_q};
      standby_o           <= standby;
    end
  end

endmodule
`default_nettype wire

// file: tb/sss_checker.sv
// Port assertions for sss_top, bound from the testbench.
// Assumes one mclk_i domain and async active-low reset.
`timescale 1ns/1ps
`default_nettype none
module sss_checker (
  input wire logic       mclk_i,
  input wire logic       rst_n_i,
  input wire logic       serial_frame_enable_i,
  input wire logic       bemf_missing_i,
  input wire logic       bemf_zc_i,
  input wire logic       probe_hit_i,
  input wire logic [2:0] phase_o,
  input wire logic       spindle_drive_en_o,
  input wire logic       vcm_drive_en_o,
  input wire logic       retract_start_o,
  input wire logic       zero_cross_toggle_o,
  input wire logic       probe_arm_o,
  input wire logic       standby_o,
  input wire logic       serial_io_line_oe_o
);
  // Windows of eight cover the pin filter delay
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  AST_RETR: assert property (retract_start_o |-> ##[0:2] standby_o ##1 !retract_start_o)
    else $error("bad retract pulse");
  AST_TRIP: assert property (standby_o [*2] |-> !spindle_drive_en_o)
    else $error("spindle driven in standby");
  AST_STALL: assert property (bemf_missing_i [*8] |-> !spindle_drive_en_o && !vcm_drive_en_o)
    else $error("outputs driven while stalled");
  AST_PRNG: assert property (phase_o inside {[3'h1:3'h6]})
    else $error("phase out of range");
  AST_PSTEP: assert property (!$stable(phase_o) |-> phase_o == 3'h1 ||
    phase_o == $past(phase_o) % 3'h6 + 3'h1 ||
    phase_o == ($past(phase_o) + 3'h1) % 3'h6 + 3'h1) else $error("phase jumped");
  AST_PROBE: assert property ((probe_arm_o && $stable(probe_hit_i)) [*8] |->
    zero_cross_toggle_o == probe_hit_i) else $error("probe flag wrong");
  AST_ZCT: assert property ($changed(bemf_zc_i) && !probe_arm_o && !standby_o |->
    ##[1:8] $changed(zero_cross_toggle_o)) else $error("no toggle on crossing");
  AST_OE: assert property (!serial_frame_enable_i [*8] |-> !serial_io_line_oe_o)
    else $error("data driven outside frame");
endmodule
`default_nettype wire

// file: tb/sss_host_model.sv
// Host serial master for the spindle block's register port.
// Assumes calls start after mclk_i falls; link clock idles low.
`timescale 1ns/1ps
`default_nettype none
module sss_host_model (
  input  wire logic mclk_i,
  input  wire logic dev_d_i,
  input  wire logic dev_oe_i,
  output logic      sen_o,
  output logic      sclk_o,
  output logic      sio_o
);
  logic hd = 1'b0;
  // Device wins while driving; on read data bits the released line flips every bit
  assign sio_o = dev_oe_i ? dev_d_i : hd;
  initial begin
    sen_o = 1'b0;
    sclk_o = 1'b0;
  end
  // 16-bit frame, 80 ns halves; read bits taken just before each fall
  task automatic xfer(input logic [15:0] f, output logic [7:0] rd);
    sen_o = 1'b1;
    for (int i = 0; i < 16; i++) begin
      hd = (i < 8 || !f[0]) ? f[i] : ~hd;
      repeat (4) @(negedge mclk_i);
      sclk_o = 1'b1;
      repeat (4) @(negedge mclk_i);
      if (i > 7) rd[i - 8] = sio_o;
      sclk_o = 1'b0;
    end
    repeat (4) @(negedge mclk_i);
    sen_o = 1'b0;
    hd = ~hd;
    repeat (8) @(negedge mclk_i);
  endtask
endmodule
`default_nettype wire

// file: tb/tb.sv
// Bench for sss_top: serial host model, queued expected values.
// Assumes sss_pkg, checker and host model compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "sss_map.svh"
module tb;
  localparam int RS = 300;
  localparam int AL = 400;
  localparam int IN = 1200;
  localparam logic [7:0] ID = 8'h5a; // Arbitrary revision value
  logic mclk_i = 0, rst_n_i = 0, ce_i = 1, power_good_n_i = 1, temp_trip_i = 0;
  logic temp_recovered_i = 0, temp_warn_i = 0, bemf_missing_i = 0, bemf_mask_n_i = 1;
  logic speed_ok_i = 1, decel_fast_i = 0, bemf_zc_i = 0, probe_hit_i = 0;
  wire logic serial_frame_enable_i, serial_clk_i, serial_io_line_i;
  logic serial_io_line_o, serial_io_line_oe_o, spindle_drive_en_o, vcm_drive_en_o;
  logic retract_start_o, zero_cross_toggle_o, probe_arm_o, standby_o;
  logic [2:0] phase_o;
  logic [1:0] probe_limit_o;
  logic [7:0] seen, r, e;
  logic [7:0] exp_q[$];
  event got;
  int n_mismatch = 0, samples_checked = 0, seed = 4, cyc = 0, t0, n_ret = 0;
  sss_top #(.ALIGN_CYC(AL), .INCR_CYC(IN), .RESYNC_CYC(RS), .ZC_MIN_CYC(10),
    .DEVICE_REV(ID)) sss_top_inst (.*);
  sss_host_model sss_host_model_inst (.mclk_i, .dev_d_i(serial_io_line_o),
    .dev_oe_i(serial_io_line_oe_o), .sen_o(serial_frame_enable_i),
    .sclk_o(serial_clk_i), .sio_o(serial_io_line_i));
  // 50 MHz system clock
  initial begin
    forever #10 mclk_i = ~mclk_i;
  end
  // Cycle count, also the hang guard; retract pulses counted too
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    n_ret <= n_ret + retract_start_o;
    if (cyc == 40000) begin
      n_mismatch++;
      close_out();
    end
  end
  task automatic check(input logic [7:0] s, input logic [7:0] x);
    samples_checked++;
    if (s !== x) begin
      n_mismatch++;
      $display("MISMATCH %0t seen %h expected %h", $time, s, x);
    end
  endtask
  task automatic close_out();
    if (n_mismatch == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Each result pairs with the oldest note
  always @(got) check(seen, exp_q.pop_front());
  task automatic port(input logic [7:0] v, input logic [7:0] x);
    exp_q.push_back(x);
    seen = v;
    ->got;
    #1;
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] x);
    sss_host_model_inst.xfer({8'h00, a, 1'b1}, r);
    port(r, x);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    sss_host_model_inst.xfer({d, a, 1'b0}, r);
  endtask
  task automatic wait_to(input int n);
    while (cyc - t0 < n) @(negedge mclk_i);
  endtask
  // Main sequence
  initial begin
    repeat (5) @(posedge mclk_i);
    @(negedge mclk_i);
    rst_n_i = 1;
    repeat (6) @(negedge mclk_i);
    rd(`SSS_ADDR_CHIP_ID, ID);
    rd(7'h2e, 8'h00);
    wr(`SSS_ADDR_STATUS, 8'h00);
    // Random flag sources, each read twice
    for (int k = 0; k < 6; k++) begin
      {temp_warn_i, bemf_missing_i, bemf_mask_n_i, speed_ok_i, decel_fast_i} = 5'($random(seed));
      repeat (10) @(negedge mclk_i);
      e = {2'b11, speed_ok_i, bemf_mask_n_i, decel_fast_i, !bemf_missing_i, !temp_warn_i, 1'b1};
      repeat (2) rd(`SSS_ADDR_STATUS, e);
    end
    {temp_warn_i, bemf_missing_i, bemf_mask_n_i, speed_ok_i, decel_fast_i} = 5'b00110;
    for (int k = 0; k < 4; k++) begin
      wr(`SSS_ADDR_PROBE, 8'h08 | 8'(k << 4));
      probe_hit_i = 1'(k);
      repeat (10) @(negedge mclk_i);
      port({4'h0, probe_arm_o, probe_limit_o, zero_cross_toggle_o}, {5'h01, 2'(k), 1'(k)});
    end
    wr(`SSS_ADDR_PROBE, 8'h00);
    probe_hit_i = 0;
    // Host-timed stepping start
    wr(`SSS_ADDR_SPIN_CTRL, 8'h1c);
    wr(`SSS_ADDR_SPIN_CTRL, 8'h18);
    port({5'h0, phase_o}, 8'h01);
    for (int k = 1; k < 7; k++) begin
      wr(`SSS_ADDR_SPIN_CTRL, 8'h19);
      wr(`SSS_ADDR_SPIN_CTRL, 8'h18);
      port({5'h0, phase_o}, 8'(k % 6 + 1));
    end
    // Hand-over after host stepping goes straight to zero-crossing control
    repeat (150) @(negedge mclk_i);
    wr(`SSS_ADDR_SPIN_CTRL, 8'h1a);
    rd(`SSS_ADDR_STATUS, 8'h77);
    // Internal start, plain then doubled
    for (int d = 1; d < 3; d++) begin
      wr(`SSS_ADDR_SYSCTRL, 8'((d - 1) << 4));
      wr(`SSS_ADDR_SPIN_CTRL, 8'h1c);
      wr(`SSS_ADDR_SPIN_CTRL, 8'h1a);
      t0 = cyc;
      wait_to(RS + 100);
      port({5'h0, phase_o}, 8'h01);
      rd(`SSS_ADDR_STATUS, 8'hb7);
      wait_to(RS + (AL + IN / 2) * d);
      port({5'h0, phase_o}, 8'h03);
      rd(`SSS_ADDR_STATUS, 8'hb7);
      wait_to(RS + (AL + IN) * d + 100);
      port({5'h0, phase_o}, 8'h05);
      rd(`SSS_ADDR_STATUS, 8'h77);
    end
    for (int k = 0; k < 2; k++) begin
      bemf_zc_i = ~bemf_zc_i;
      repeat (20) @(negedge mclk_i);
      port({5'h0, phase_o}, 8'(6 - 5 * k));
    end
    // Thermal trip, refused write, recovery
    temp_trip_i = 1;
    repeat (10) @(negedge mclk_i);
    port({5'h0, vcm_drive_en_o, standby_o, spindle_drive_en_o}, 8'h06);
    port(8'(n_ret), 8'h01);
    wr(`SSS_ADDR_PROBE, 8'h08);
    port({7'h0, probe_arm_o}, 8'h00);
    rd(`SSS_ADDR_STATUS, 8'hf6);
    temp_trip_i = 0;
    temp_recovered_i = 1;
    repeat (10) @(negedge mclk_i);
    rd(`SSS_ADDR_STATUS, 8'hf7);
    port({6'h0, standby_o, probe_arm_o}, 8'h00);
    // Two crossings closer than the minimum gap raise the fault flag
    bemf_zc_i = ~bemf_zc_i;
    repeat (5) @(negedge mclk_i);
    bemf_zc_i = ~bemf_zc_i;
    repeat (10) @(negedge mclk_i);
    rd(`SSS_ADDR_STATUS, 8'hff);
    close_out();
  end
endmodule
bind sss_top sss_checker sss_checker_inst (.*);
`default_nettype wire
